// >>> common/frqpe_pkg.sv
/*
  Package for the frequency protection element: modes, gradient sense,
  field widths, window limits and timing constants.
  Assumes a 20 MHz system clock.
*/
package frqpe_pkg;

  // Operating modes, one-hot
  typedef enum logic [4:0] {
    FRQPE_MODE_UNDER          = 5'h01,
    FRQPE_MODE_OVER           = 5'h02,
    FRQPE_MODE_GRADIENT       = 5'h04,
    FRQPE_MODE_UNDER_GRADIENT = 5'h08,
    FRQPE_MODE_OVER_GRADIENT  = 5'h10
  } frqpe_mode_t;

  // Gradient sense selection
  typedef enum logic [1:0] {
    FRQPE_SENSE_POS = 2'h0,
    FRQPE_SENSE_NEG = 2'h1,
    FRQPE_SENSE_ABS = 2'h2
  } frqpe_sense_t;

  // Element sequencer states, one-hot
  typedef enum logic [2:0] {
    FRQPE_ST_IDLE  = 3'h1,
    FRQPE_ST_TIMING = 3'h2,
    FRQPE_ST_TRIP  = 3'h4
  } frqpe_state_t;

  // Data widths
  localparam int FRQPE_FREQ_W  = 16;  // Frequency, unsigned, mHz units
  localparam int FRQPE_GRAD_W  = 16;  // Gradient, signed
  localparam int FRQPE_VOLT_W  = 16;  // Line voltage magnitude
  localparam int FRQPE_DELAY_W = 16;  // Trip delay in ticks
  localparam int FRQPE_WIN_W   = 4;   // Window in periods

  // Gradient measuring window limits, nominal periods
  localparam logic [3:0] FRQPE_WIN_MIN = 4'h2;
  localparam logic [3:0] FRQPE_WIN_MAX = 4'ha;
  localparam int FRQPE_HIST_DEPTH = 10;

  // Clock and tick timing
  localparam int FRQPE_CLK_HZ     = 20000000;
  localparam int FRQPE_TICK_US    = 1000;  // Delay tick period, us
  localparam int FRQPE_TICK_CYC   = FRQPE_CLK_HZ / 1000000 * FRQPE_TICK_US;

  // Low-voltage block hold after recovery
  localparam int FRQPE_HOLD_MS    = 500;
  localparam int FRQPE_HOLD_CYC   = (FRQPE_CLK_HZ / 1000) * FRQPE_HOLD_MS;

endpackage : frqpe_pkg

// >>> core/frqpe_tick_gen.sv
/*
  Fixed-rate tick generator for the trip delay timer.
  Assumes a synchronous active-high enable from the top module.
*/
`timescale 1ns/1ns
module frqpe_tick_gen #(
  parameter int TICK_CYC = 20000
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  // Tick
  output logic      tick_out
);
  import frqpe_pkg::*;

  localparam int CNT_W = $clog2(TICK_CYC + 1);

  logic [CNT_W-1:0] cnt_ff;

  // Free-running divider; one-cycle tick at wrap
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff   <= '0;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      if (cnt_ff == CNT_W'(TICK_CYC - 1)) begin
        cnt_ff   <= '0;
        tick_out <= 1'b1;
      end else begin
        cnt_ff   <= cnt_ff + 1'b1;
        tick_out <= 1'b0;
      end
    end
  end

endmodule : frqpe_tick_gen

// >>> core/frqpe_gradient.sv
/*
  Gradient calculator: keeps a history of raw frequency samples, one per
  zero crossing, and forms the signed difference across the measuring window,
  then averages it over a stabilizing window.
  Assumes frequency samples arrive with a one-cycle strobe.
*/
`timescale 1ns/1ns
module frqpe_gradient #(
  parameter int DEPTH = 10
) (
  // Clock and reset
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           ce_in,
  input  wire logic                           clr_in,
  // Raw frequency
  input  wire logic                           strobe_in,
  input  wire logic [frqpe_pkg::FRQPE_FREQ_W-1:0] freq_in,
  input  wire logic [frqpe_pkg::FRQPE_WIN_W-1:0]  window_in,
  input  wire logic [frqpe_pkg::FRQPE_WIN_W-1:0]  stab_in,
  // Gradient
  output logic signed [frqpe_pkg::FRQPE_GRAD_W-1:0] grad_out,
  output logic                                     valid_out
);
  import frqpe_pkg::*;

  logic [FRQPE_FREQ_W-1:0]        hist_ff [DEPTH+1];
  logic [FRQPE_WIN_W:0]           fill_ff;
  logic signed [FRQPE_GRAD_W-1:0] gsum_ff [DEPTH];
  logic [FRQPE_WIN_W-1:0]         win_c;
  logic [FRQPE_WIN_W-1:0]         stab_c;
  logic signed [FRQPE_FREQ_W:0]   diff_c;
  logic signed [FRQPE_GRAD_W+3:0] acc_c;

  // Clamp a window setting into the legal range
  function automatic logic [FRQPE_WIN_W-1:0] clamp_win(input logic [FRQPE_WIN_W-1:0] w);
    if (w < FRQPE_WIN_MIN) return FRQPE_WIN_MIN;
    if (w > FRQPE_WIN_MAX) return FRQPE_WIN_MAX;
    return w;
  endfunction : clamp_win

  assign win_c  = clamp_win(window_in);
  assign stab_c = (stab_in == 4'h0) ? 4'h1 : clamp_win(stab_in);

  // Signed difference newest minus window-old; positive when rising
  always_comb begin
    diff_c = $signed({1'b0, freq_in}) - $signed({1'b0, hist_ff[win_c - 1'b1]});
  end

  // Average over stabilizing window of past gradients
  always_comb begin
    acc_c = (FRQPE_GRAD_W+4)'(diff_c);
    for (int i = 0; i < DEPTH - 1; i++) begin
      if (4'(i + 1) < stab_c) acc_c = acc_c + (FRQPE_GRAD_W+4)'(gsum_ff[i]);
    end
  end

  // History shift at every zero-crossing sample unless cleared, taken from raw frequency
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill_ff   <= '0;
      valid_out <= 1'b0;
      grad_out  <= '0;
      for (int i = 0; i <= DEPTH; i++) hist_ff[i] <= '0;
      for (int i = 0; i < DEPTH; i++) gsum_ff[i] <= '0;
    end else if (ce_in) begin
      if (clr_in) begin
        fill_ff   <= '0;
        valid_out <= 1'b0;
        grad_out  <= '0;
      end else if (strobe_in) begin
        hist_ff[0] <= freq_in;
        for (int i = 1; i <= DEPTH; i++) hist_ff[i] <= hist_ff[i-1];
        gsum_ff[0] <= FRQPE_GRAD_W'(diff_c);
        for (int i = 1; i < DEPTH; i++) gsum_ff[i] <= gsum_ff[i-1];
        if (fill_ff < 5'(win_c) + 5'(stab_c)) begin
          fill_ff   <= fill_ff + 1'b1;
          valid_out <= 1'b0;
          grad_out  <= '0;
        end else begin
          valid_out <= 1'b1;
          grad_out  <= FRQPE_GRAD_W'(acc_c / $signed({1'b0, stab_c}));
        end
      end
    end
  end

endmodule : frqpe_gradient

// >>> core/frqpe_element.sv
/*
  Frequency protection element top: low-voltage blocking, frequency and
  gradient threshold compare per selected mode, instant alarm and trip
  after delay.
  Assumes the measurement front end gives per-crossing raw frequency with
  a strobe, and line voltage magnitudes, all synchronous to CLK_IN.
*/
`timescale 1ns/1ns
module frqpe_element #(
  parameter int HOLD_CYC = frqpe_pkg::FRQPE_HOLD_CYC,
  parameter int TICK_CYC = frqpe_pkg::FRQPE_TICK_CYC
) (
  // Clock, reset, enable
  input  wire logic                                  CLK_IN,
  input  wire logic                                  RST_N_IN,
  input  wire logic                                  CE_IN,
  // Measurement front end
  input  wire logic                                  FREQ_STROBE_IN,
  input  wire logic [frqpe_pkg::FRQPE_FREQ_W-1:0]    FREQ_IN,
  input  wire logic [frqpe_pkg::FRQPE_VOLT_W-1:0]    LINE_VOLTAGE_AB_IN,
  input  wire logic [frqpe_pkg::FRQPE_VOLT_W-1:0]    LINE_VOLTAGE_BC_IN,
  input  wire logic [frqpe_pkg::FRQPE_VOLT_W-1:0]    LINE_VOLTAGE_CA_IN,
  // Settings
  input  wire frqpe_pkg::frqpe_mode_t                MODE_IN,
  input  wire frqpe_pkg::frqpe_sense_t               SENSE_IN,
  input  wire logic [frqpe_pkg::FRQPE_FREQ_W-1:0]    PICKUP_FREQ_IN,
  input  wire logic [frqpe_pkg::FRQPE_GRAD_W-1:0]    PICKUP_GRAD_IN,
  input  wire logic [frqpe_pkg::FRQPE_DELAY_W-1:0]   TRIP_DELAY_IN,
  input  wire logic [frqpe_pkg::FRQPE_VOLT_W-1:0]    VOLT_BLOCK_LEVEL_IN,
  input  wire logic [frqpe_pkg::FRQPE_WIN_W-1:0]     GRADIENT_MEASURE_WINDOW_IN,
  input  wire logic [frqpe_pkg::FRQPE_WIN_W-1:0]     GRADIENT_STABILIZE_WINDOW_IN,
  input  wire logic                                  BLOCK_IN,
  // Status
  output logic                                       ALARM_OUT,
  output logic                                       TRIP_OUT,
  output logic                                       VOLT_BLOCKED_OUT,
  output logic [frqpe_pkg::FRQPE_FREQ_W-1:0]         FREQ_OUT,
  output logic [frqpe_pkg::FRQPE_GRAD_W-1:0]         GRAD_OUT
);
  import frqpe_pkg::*;

  localparam int HOLD_W = $clog2(HOLD_CYC + 1);

  logic                           rst_sync1_ff;
  logic                           rst_sync2_ff;
  logic                           rst_n;
  logic                           tick;
  logic                           all_low_c;
  logic [HOLD_W-1:0]              hold_ff;
  logic                           vblock_ff;
  logic                           freq_valid_ff;
  logic [FRQPE_FREQ_W-1:0]        freq_ff;
  logic signed [FRQPE_GRAD_W-1:0] grad_w;
  logic                           grad_valid_w;
  logic                           under_c;
  logic                           over_c;
  logic                           grad_c;
  logic                           cond_c;
  frqpe_state_t                   state_ff;
  frqpe_state_t                   nxt_state;
  logic [FRQPE_DELAY_W-1:0]       timer_ff;

  // Gradient compare by sense; threshold is a magnitude
  function automatic logic grad_hit(input logic signed [FRQPE_GRAD_W-1:0] g,
                                    input logic [FRQPE_GRAD_W-1:0] thr,
                                    input frqpe_sense_t s);
    logic signed [FRQPE_GRAD_W:0] gw;
    logic signed [FRQPE_GRAD_W:0] tw;
    gw = (FRQPE_GRAD_W+1)'(g);
    tw = $signed({1'b0, thr});
    case (s)
      FRQPE_SENSE_POS: return gw >= tw;
      FRQPE_SENSE_NEG: return gw <= -tw;
      FRQPE_SENSE_ABS: return (gw >= tw) || (gw <= -tw);
      default:         return 1'b0;
    endcase
  endfunction : grad_hit

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign rst_n = rst_sync2_ff;

  // Delay tick source
  frqpe_tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk_in   (CLK_IN),
    .rst_n_in (rst_n),
    .ce_in    (CE_IN),
    .tick_out (tick)
  );

  // All three line voltages under the block level
  assign all_low_c = (LINE_VOLTAGE_AB_IN < VOLT_BLOCK_LEVEL_IN) &&
                     (LINE_VOLTAGE_BC_IN < VOLT_BLOCK_LEVEL_IN) &&
                     (LINE_VOLTAGE_CA_IN < VOLT_BLOCK_LEVEL_IN);

  // Low-voltage block with hold; reset starts blocked so no early trip
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      vblock_ff <= 1'b1;
      hold_ff   <= '0;
    end else if (CE_IN) begin
      if (all_low_c) begin
        vblock_ff <= 1'b1;
        hold_ff   <= '0;
      end else if (vblock_ff) begin
        if (hold_ff == HOLD_W'(HOLD_CYC - 1)) begin
          vblock_ff <= 1'b0;
        end else begin
          hold_ff <= hold_ff + 1'b1;
        end
      end
    end
  end

  // Frequency latch per zero crossing; forced to zero while blocked
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      freq_ff       <= '0;
      freq_valid_ff <= 1'b0;
    end else if (CE_IN) begin
      if (vblock_ff) begin
        freq_ff       <= '0;
        freq_valid_ff <= 1'b0;
      end else if (FREQ_STROBE_IN) begin
        freq_ff       <= FREQ_IN;
        freq_valid_ff <= 1'b1;
      end
    end
  end

  // Gradient path, cleared while voltage is blocked
  frqpe_gradient #(
    .DEPTH (FRQPE_HIST_DEPTH)
  ) u_grad (
    .clk_in    (CLK_IN),
    .rst_n_in  (rst_n),
    .ce_in     (CE_IN),
    .clr_in    (vblock_ff),
    .strobe_in (FREQ_STROBE_IN),
    .freq_in   (FREQ_IN),
    .window_in (GRADIENT_MEASURE_WINDOW_IN),
    .stab_in   (GRADIENT_STABILIZE_WINDOW_IN),
    .grad_out  (grad_w),
    .valid_out (grad_valid_w)
  );

  // Threshold compares on the latched values
  assign under_c = freq_valid_ff && (freq_ff < PICKUP_FREQ_IN);
  assign over_c  = freq_valid_ff && (freq_ff > PICKUP_FREQ_IN);
  assign grad_c  = grad_valid_w && grad_hit(grad_w, PICKUP_GRAD_IN, SENSE_IN);

  // Mode selects which compares form the pickup condition
  always_comb begin
    case (MODE_IN)
      FRQPE_MODE_UNDER:          cond_c = under_c;
      FRQPE_MODE_OVER:           cond_c = over_c;
      FRQPE_MODE_GRADIENT:       cond_c = grad_c;
      FRQPE_MODE_UNDER_GRADIENT: cond_c = under_c && grad_c;
      FRQPE_MODE_OVER_GRADIENT:  cond_c = over_c && grad_c;
      default:                   cond_c = 1'b0;
    endcase
  end

  // Sequencer next state; any loss of condition or block returns to idle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FRQPE_ST_IDLE: begin
        if (cond_c && !BLOCK_IN && !vblock_ff) nxt_state = FRQPE_ST_TIMING;
      end
      FRQPE_ST_TIMING: begin
        if (!cond_c || BLOCK_IN || vblock_ff) nxt_state = FRQPE_ST_IDLE;
        else if (tick && (timer_ff + 1'b1 >= TRIP_DELAY_IN))
          nxt_state = FRQPE_ST_TRIP;
      end
      FRQPE_ST_TRIP: begin
        if (!cond_c || BLOCK_IN || vblock_ff) nxt_state = FRQPE_ST_IDLE;
      end
      default: nxt_state = FRQPE_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= FRQPE_ST_IDLE;
    end else if (CE_IN) begin
      state_ff <= nxt_state;
    end
  end

  // Delay timer counts ticks only while timing; zero delay trips on first tick
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= '0;
    end else if (CE_IN) begin
      if (nxt_state != FRQPE_ST_TIMING) begin
        timer_ff <= '0;
      end else if (state_ff == FRQPE_ST_TIMING && tick) begin
        timer_ff <= timer_ff + 1'b1;
      end
    end
  end

  // Registered outputs; alarm follows the condition one cycle later
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ALARM_OUT        <= 1'b0;
      TRIP_OUT         <= 1'b0;
      VOLT_BLOCKED_OUT <= 1'b1;
      FREQ_OUT         <= '0;
      GRAD_OUT         <= '0;
    end else if (CE_IN) begin
      ALARM_OUT        <= (nxt_state != FRQPE_ST_IDLE);
      TRIP_OUT         <= (nxt_state == FRQPE_ST_TRIP);
      VOLT_BLOCKED_OUT <= vblock_ff;
      FREQ_OUT         <= freq_ff;
      GRAD_OUT         <= grad_w;
    end
  end

  // Checks on the sequencer, outputs, voltage block and frequency latch
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  alarm_on_cond_a: assert property (CE_IN && cond_c && !BLOCK_IN && !vblock_ff
                                    && state_ff == FRQPE_ST_IDLE |=> ALARM_OUT)
    else $error("alarm not raised on pickup");
  alarm_drop_a: assert property (CE_IN && state_ff != FRQPE_ST_IDLE && !cond_c
                                 |=> !ALARM_OUT && !TRIP_OUT)
    else $error("alarm held after condition lost");
  trip_needs_alarm_a: assert property (TRIP_OUT |-> ALARM_OUT)
    else $error("trip without alarm");
  trip_needs_cond_a: assert property (CE_IN && !TRIP_OUT ##1 TRIP_OUT |-> $past(cond_c))
    else $error("trip without held condition");
  block_stops_alarm_a: assert property (CE_IN && BLOCK_IN |=> !ALARM_OUT)
    else $error("alarm while blocked");
  vblock_on_low_a: assert property (CE_IN && all_low_c |=> vblock_ff)
    else $error("low voltage did not block");
  vblock_hold_a: assert property (CE_IN && vblock_ff && !all_low_c && hold_ff == '0
                                  |=> vblock_ff)
    else $error("block released without hold");
  freq_zero_blocked_a: assert property (CE_IN && vblock_ff |=> freq_ff == '0)
    else $error("frequency not forced to zero");
  timer_clear_a: assert property (CE_IN && state_ff == FRQPE_ST_IDLE |=> timer_ff == '0
                                  || state_ff == FRQPE_ST_TIMING)
    else $error("timer not cleared");

  alarm_cov_c: cover property (!ALARM_OUT ##1 ALARM_OUT);
  trip_cov_c: cover property (ALARM_OUT && !TRIP_OUT ##1 TRIP_OUT);
  abort_cov_c: cover property (ALARM_OUT && !TRIP_OUT ##1 !ALARM_OUT);
  release_cov_c: cover property (vblock_ff ##1 !vblock_ff);

endmodule : frqpe_element

// >>> tb/frqpe_front_end.sv
/*
  Behavioural model of the three-phase voltage measurement front end.
  Assumes the bench loads a start frequency and a per-crossing step.
*/
`timescale 1ns/1ns
module frqpe_front_end (
  // Clock and reset
  input  wire logic                               clk_in,
  input  wire logic                               rst_n_in,
  // Commands from the bench
  input  wire logic                               load_in,
  input  wire logic [frqpe_pkg::FRQPE_FREQ_W-1:0] base_in,
  input  wire logic [frqpe_pkg::FRQPE_FREQ_W-1:0] step_in,
  input  wire logic [7:0]                         period_in,
  input  wire logic [2:0]                         low_in,
  // Towards the element
  output logic                                    strobe_out,
  output logic [frqpe_pkg::FRQPE_FREQ_W-1:0]      freq_out,
  output logic [frqpe_pkg::FRQPE_VOLT_W-1:0]      volt_ab_out,
  output logic [frqpe_pkg::FRQPE_VOLT_W-1:0]      volt_bc_out,
  output logic [frqpe_pkg::FRQPE_VOLT_W-1:0]      volt_ca_out
);
  import frqpe_pkg::*;
  logic [7:0]              cnt_ff;
  logic                    strobe_ff;
  logic [FRQPE_FREQ_W-1:0] cur_ff;

  // Zero-crossing pacing; a long period models a slow answer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff    <= 8'h00;
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= (cnt_ff >= period_in - 8'h01);
      cnt_ff    <= (cnt_ff >= period_in - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
    end
  end

  // Frequency ramps by one step after each crossing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_ff <= 16'h0000;
    end else begin
      cur_ff <= load_in ? base_in : (strobe_ff ? cur_ff + step_in : cur_ff);
    end
  end

  // Value only valid with the strobe; inverted otherwise so stale reads show
  assign strobe_out  = strobe_ff;
  assign freq_out    = strobe_ff ? cur_ff : ~cur_ff;
  assign volt_ab_out = low_in[0] ? 16'h0100 : 16'h4000;
  assign volt_bc_out = low_in[1] ? 16'h0100 : 16'h4000;
  assign volt_ca_out = low_in[2] ? 16'h0100 : 16'h4000;
endmodule : frqpe_front_end

// >>> tb/testbench.sv
/*
  Self-checking bench for the frequency protection element.
  Assumes the front end model and short hold and tick counts.
*/
`timescale 1ns/1ns
module testbench;
  import frqpe_pkg::*;
  localparam int HOLD = 20;
  localparam int TICK = 4;
  localparam int DLY  = 8;
  logic         clk = 1'b0;
  logic         ce = 1'b1;
  logic         rst_n = 1'b0;
  logic         load = 1'b0;
  logic [15:0]  base = 16'hc350;
  logic [15:0]  stp = 16'h0000;
  logic [7:0]   period = 8'h08;
  logic [2:0]   low = 3'h0;
  frqpe_mode_t  mode = FRQPE_MODE_OVER;
  frqpe_sense_t sense = FRQPE_SENSE_ABS;
  logic [15:0]  pick_f = 16'hc350;
  logic [15:0]  delay = 16'hffff;
  logic [3:0]   win = 4'h2;
  logic         blk = 1'b0;
  logic         trip_seen = 1'b0;
  logic         strobe, alarm, trip, vblk;
  logic [15:0]  freq, v_ab, v_bc, v_ca, freq_q, grad_q, f;
  logic [31:0]  rnd = 32'h14;
  int           mismatches = 0;
  int           cmp_count = 0;

  always #25 clk = ~clk;
  always @(posedge clk) if (trip === 1'b1) trip_seen = 1'b1;

  frqpe_front_end u_fe (.clk_in(clk), .rst_n_in(rst_n), .load_in(load), .base_in(base),
    .step_in(stp), .period_in(period), .low_in(low), .strobe_out(strobe), .freq_out(freq),
    .volt_ab_out(v_ab), .volt_bc_out(v_bc), .volt_ca_out(v_ca));

  frqpe_element #(.HOLD_CYC(HOLD), .TICK_CYC(TICK)) u_dut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .CE_IN(ce), .FREQ_STROBE_IN(strobe), .FREQ_IN(freq), .LINE_VOLTAGE_AB_IN(v_ab),
    .LINE_VOLTAGE_BC_IN(v_bc), .LINE_VOLTAGE_CA_IN(v_ca), .MODE_IN(mode), .SENSE_IN(sense),
    .PICKUP_FREQ_IN(pick_f), .PICKUP_GRAD_IN(16'h0050), .TRIP_DELAY_IN(delay),
    .VOLT_BLOCK_LEVEL_IN(16'h1000), .GRADIENT_MEASURE_WINDOW_IN(win),
    .GRADIENT_STABILIZE_WINDOW_IN(4'h2), .BLOCK_IN(blk), .ALARM_OUT(alarm),
    .TRIP_OUT(trip), .VOLT_BLOCKED_OUT(vblk), .FREQ_OUT(freq_q), .GRAD_OUT(grad_q));

  // Xorshift keeps the random run repeatable
  function automatic logic [31:0] next_rnd();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : next_rnd

  // Gradient of a steady ramp: newest sample minus the one a full window back
  function automatic int exp_grad(input int st, input int w);
    int we;
    we = (w < 2) ? 2 : ((w > 10) ? 10 : w);
    return st * we;
  endfunction : exp_grad

  // Pickup condition per mode and sense
  function automatic logic exp_alarm(input frqpe_mode_t m, input frqpe_sense_t s,
                                     input int fv, input int pf, input int g, input int pg);
    logic fu, fo, gc;
    fu = fv < pf;
    fo = fv > pf;
    gc = (s != FRQPE_SENSE_NEG && g >= pg) || (s != FRQPE_SENSE_POS && g <= -pg);
    return (m == FRQPE_MODE_UNDER) ? fu : (m == FRQPE_MODE_OVER) ? fo :
           (m == FRQPE_MODE_GRADIENT) ? gc : (m == FRQPE_MODE_UNDER_GRADIENT) ? (fu && gc) :
           (fo && gc);
  endfunction : exp_alarm

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic load_freq(input logic [15:0] fv, input logic [15:0] st);
    base = fv;
    stp = st;
    load = 1'b1;
    step();
    load = 1'b0;
  endtask : load_freq

  // Strobes are registered in the model, so they are settled after each step
  task automatic wait_strobes(input int n);
    repeat (n) begin
      step();
      while (strobe !== 1'b1) step();
    end
    repeat (3) step();
  endtask : wait_strobes

  task automatic run_trip(input frqpe_mode_t m, input logic [15:0] fv);
    int n;
    n = 0;
    mode = m;
    delay = 16'(DLY);
    repeat (3) step();
    load_freq(fv, 16'h0000);
    while (alarm !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    chk(alarm === 1'b1 && trip === 1'b0, "alarm missing or early trip");
    n = 0;
    while (trip !== 1'b1 && n < 80) begin
      step();
      n++;
    end
    chk(n >= (DLY - 1) * TICK && n <= DLY * TICK + 3, "trip timing");
    blk = 1'b1;
    repeat (2) step();
    chk(alarm === 1'b0 && trip === 1'b0, "blocking ignored");
    blk = 1'b0;
  endtask : run_trip

  task automatic run_grad(input frqpe_mode_t m, input frqpe_sense_t s, input logic [15:0] st,
                          input logic [3:0] w, input logic [15:0] pf);
    int g;
    logic e;
    g = exp_grad($signed(st), w);
    e = exp_alarm(m, s, 50000, pf, g, 80);
    mode = m;
    sense = s;
    win = w;
    pick_f = pf;
    load_freq(16'hc350, st);
    wait_strobes(16);
    chk(grad_q === 16'(g), "gradient value");
    chk(alarm === e, "gradient alarm");
    chk(trip === e, "gradient trip");
  endtask : run_grad

  task automatic stop_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #(50 * 20000);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (5) step();
    rst_n = 1'b1;
    step();
    chk(vblk === 1'b1, "not blocked after reset");
    repeat (HOLD + 10) step();
    chk(vblk === 1'b0, "block not released");
    run_trip(FRQPE_MODE_UNDER, 16'hbf68);
    run_trip(FRQPE_MODE_OVER, 16'hc738);
    // Pickup lost well before the delay runs out
    mode = FRQPE_MODE_UNDER;
    load_freq(16'hbf68, 16'h0000);
    wait_strobes(1);
    trip_seen = 1'b0;
    load_freq(16'hc738, 16'h0000);
    wait_strobes(1);
    chk(alarm === 1'b0 && trip === 1'b0 && trip_seen === 1'b0, "trip after drop");
    // Random thresholds, frequencies and crossing rates; first one on the threshold
    delay = 16'hffff;
    for (int i = 0; i < 16; i++) begin
      void'(next_rnd());
      mode = rnd[0] ? FRQPE_MODE_OVER : FRQPE_MODE_UNDER;
      pick_f = rnd[31:16];
      period = {4'h0, rnd[4:1]} + 8'h03;
      void'(next_rnd());
      f = (i == 0) ? pick_f : rnd[15:0];
      load_freq(f, 16'h0000);
      wait_strobes(2);
      chk(alarm === exp_alarm(mode, sense, f, pick_f, 0, 80), "frequency alarm");
      chk(freq_q === f, "frequency value");
    end
    // Clock enable low must freeze the latched frequency and the block state
    ce = 1'b0;
    load_freq(16'h1234, 16'h0000);
    repeat (20) step();
    chk(freq_q === f && vblk === 1'b0, "state moved while disabled");
    ce = 1'b1;
    // Low-voltage blocking needs all three phases low
    mode = FRQPE_MODE_UNDER;
    pick_f = 16'hc350;
    period = 8'h08;
    load_freq(16'hbf68, 16'h0000);
    wait_strobes(2);
    low = 3'h3;
    repeat (4) step();
    chk(vblk === 1'b0 && alarm === 1'b1, "blocked by two phases");
    low = 3'h7;
    repeat (3) step();
    chk(vblk === 1'b1 && freq_q === 16'h0000 && alarm === 1'b0, "not blocked");
    low = 3'h0;
    repeat (HOLD - 4) step();
    chk(vblk === 1'b1, "block released early");
    repeat (10) step();
    chk(vblk === 1'b0, "block held too long");
    // Gradient modes, senses and window limits
    delay = 16'h0002;
    run_grad(FRQPE_MODE_GRADIENT, FRQPE_SENSE_POS, 16'h0064, 4'h4, 16'hc350);
    run_grad(FRQPE_MODE_GRADIENT, FRQPE_SENSE_POS, 16'hff9c, 4'h4, 16'hc350);
    run_grad(FRQPE_MODE_GRADIENT, FRQPE_SENSE_NEG, 16'hff9c, 4'h2, 16'hc350);
    run_grad(FRQPE_MODE_GRADIENT, FRQPE_SENSE_NEG, 16'h0064, 4'ha, 16'hc350);
    run_grad(FRQPE_MODE_GRADIENT, FRQPE_SENSE_ABS, 16'hff9c, 4'h1, 16'hc350);
    run_grad(FRQPE_MODE_UNDER_GRADIENT, FRQPE_SENSE_ABS, 16'hff9c, 4'h4, 16'hea60);
    run_grad(FRQPE_MODE_UNDER_GRADIENT, FRQPE_SENSE_ABS, 16'hff9c, 4'h4, 16'h9c40);
    run_grad(FRQPE_MODE_OVER_GRADIENT, FRQPE_SENSE_POS, 16'h0064, 4'h3, 16'h9c40);
    stop_test();
  end
endmodule : testbench
